/* File: tsc_pkg.sv */
// Constants, types and helpers shared by the timer blocks
package tsc_pkg;

	// Register byte offsets
	localparam logic [4:0] TSC_OFF_CNT_LO  = 5'h00;
	localparam logic [4:0] TSC_OFF_CNT_HI  = 5'h04;
	localparam logic [4:0] TSC_OFF_CMPA_LO = 5'h08;
	localparam logic [4:0] TSC_OFF_CMPA_HI = 5'h0c;
	localparam logic [4:0] TSC_OFF_CTRL0   = 5'h10;
	localparam logic [4:0] TSC_OFF_CTRL1   = 5'h14;
	localparam logic [4:0] TSC_OFF_STAT    = 5'h18;

	// Field positions
	localparam int TSC_PAUSE_BIT = 7;
	localparam int TSC_ON_BIT    = 3;
	localparam int TSC_MODE_LSB  = 6;
	localparam int TSC_ACT_LSB   = 4;
	localparam int TSC_INIT_BIT  = 3;
	localparam int TSC_INV_BIT   = 2;
	localparam int TSC_SWAP_BIT  = 1;
	localparam int TSC_CLR_BIT   = 0;
	localparam int TSC_FLAGA_BIT = 0;
	localparam int TSC_FLAGP_BIT = 1;

	// Reset values
	localparam logic [7:0] TSC_CTRL_RST = 8'h00;
	localparam logic [9:0] TSC_CMPA_RST = 10'h000;

	// Bus responses
	localparam logic [1:0] TSC_RESP_OKAY   = 2'b00;
	localparam logic [1:0] TSC_RESP_SLVERR = 2'b10;

	// Timing counts in timer clocks
	localparam logic [10:0] TSC_STEP_TICKS = 11'h080;
	localparam logic [10:0] TSC_FULL_TICKS = 11'h400;

	// Pin action codes
	localparam logic [1:0] TSC_ACT_LOW  = 2'b01;
	localparam logic [1:0] TSC_ACT_HIGH = 2'b10;
	localparam logic [1:0] TSC_ACT_TOG  = 2'b11;
	localparam logic [1:0] TSC_ACT_OFF  = 2'b00;
	localparam logic [1:0] TSC_ACT_ON   = 2'b01;

	typedef enum logic [1:0] {
		TSC_MODE_CMP = 2'b00,
		TSC_MODE_CAP = 2'b01,
		TSC_MODE_PWM = 2'b10,
		TSC_MODE_TMR = 2'b11
	} tsc_mode_t;

	// Ticks of one period for a 3-bit period code
	function automatic logic [10:0] tscCodeTicks(input logic [2:0] code);
		tscCodeTicks = (code == 3'h0) ? TSC_FULL_TICKS
			: 11'(11'(code) * TSC_STEP_TICKS);
	endfunction

endpackage

/* File: tsc_ctl_if.sv */
// Control and event bundle between register file, counter and pin
`timescale 1ns/10ps
interface tsc_ctl_if;
	import tsc_pkg::*;
	tsc_mode_t  mode;
	logic       clrSel;
	logic       swap;
	logic       counterOn;
	logic       pause;
	logic       initLevel;
	logic       invert;
	logic [1:0] action;
	logic [2:0] periodCode;
	logic [9:0] cmpA;
	logic [9:0] cnt;
	logic       hitA;
	logic       hitP;
	logic       onRise;
	logic       pwmAct;

	modport regs (output mode, clrSel, swap, counterOn, pause, initLevel,
		invert, action, periodCode, cmpA,
		input cnt, hitA, hitP, onRise, pwmAct);
	modport core (input mode, clrSel, swap, counterOn, pause, periodCode,
		cmpA, output cnt, hitA, hitP, onRise, pwmAct);
	modport pin (input mode, action, initLevel, invert, onRise, hitA,
		pwmAct);
endinterface

/* File: tsc_count_core.sv */
// 10-bit counter with compare-A and period comparators
`timescale 1ns/10ps
module tsc_count_core
	import tsc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	tsc_ctl_if.core   ctl
);
	typedef struct packed {
		logic [9:0] cnt;
		logic       onPrev;
		logic       hitA;
		logic       hitP;
		logic       onRise;
		logic       pwmAct;
	} tsc_core_t;

	tsc_core_t s_r;
	tsc_core_t s_nxt;

	always_comb begin
		logic [10:0] inc;
		logic        pHit;
		logic        aHit;
		logic        isPwm;
		logic        clrByA;
		logic [10:0] duty;
		logic [10:0] period;
		s_nxt = s_r;
		inc = {1'b0, s_r.cnt} + 11'h001;
		// Period match: next count's top three bits equal the code, low seven bits zero
		pHit = (ctl.periodCode == 3'h0) ? inc[10]
			: (inc[9:7] == ctl.periodCode && inc[6:0] == 7'h00);
		aHit = (s_r.cnt == ctl.cmpA);
		isPwm = (ctl.mode == TSC_MODE_PWM);
		clrByA = isPwm ? ctl.swap : ctl.clrSel;
		s_nxt.onPrev = ctl.counterOn;
		s_nxt.onRise = ctl.counterOn && !s_r.onPrev;
		s_nxt.hitA = 1'b0;
		s_nxt.hitP = 1'b0;
		if (ctl.counterOn && !s_r.onPrev) begin
			s_nxt.cnt = 10'h000;
		end else if (ctl.counterOn && !ctl.pause) begin
			s_nxt.hitA = aHit;
			s_nxt.hitP = pHit && (isPwm || !ctl.clrSel);
			s_nxt.cnt = (clrByA ? aHit : pHit) ? 10'h000
				: inc[9:0];
		end
		// Roles of the two comparators in PWM
		duty = ctl.swap ? tscCodeTicks(ctl.periodCode)
			: {1'b0, ctl.cmpA};
		period = ctl.swap ? 11'({1'b0, ctl.cmpA} + 11'h001)
			: tscCodeTicks(ctl.periodCode);
		s_nxt.pwmAct = (duty >= period)
			|| ({1'b0, s_nxt.cnt} < duty);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ctl.cnt    = s_r.cnt;
	assign ctl.hitA   = s_r.hitA;
	assign ctl.hitP   = s_r.hitP;
	assign ctl.onRise = s_r.onRise;
	assign ctl.pwmAct = s_r.pwmAct;
endmodule

/* File: tsc_pin_drive.sv */
// Output pin level and enable for compare and PWM modes
`timescale 1ns/10ps
module tsc_pin_drive
	import tsc_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	tsc_ctl_if.pin    ctl,
	output logic      pinOut,
	output logic      pinOe
);
	typedef struct packed {
		logic level;
		logic out;
		logic oe;
	} tsc_pin_t;

	tsc_pin_t s_r;
	tsc_pin_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		unique case (ctl.mode)
			TSC_MODE_CMP: begin
				if (ctl.onRise) begin
					s_nxt.level = ctl.initLevel;
				end else if (ctl.hitA) begin
					unique case (ctl.action)
						TSC_ACT_LOW:  s_nxt.level = 1'b0;
						TSC_ACT_HIGH: s_nxt.level = 1'b1;
						TSC_ACT_TOG:  s_nxt.level = !s_r.level;
						default:      s_nxt.level = s_r.level;
					endcase
				end
			end
			TSC_MODE_PWM: begin
				unique case (ctl.action)
					TSC_ACT_OFF: s_nxt.level = !ctl.initLevel;
					TSC_ACT_ON:  s_nxt.level = ctl.initLevel;
					default: s_nxt.level = ctl.pwmAct ? ctl.initLevel
						: !ctl.initLevel;
				endcase
			end
			TSC_MODE_CAP,
			TSC_MODE_TMR: s_nxt.level = s_r.level;
		endcase
		s_nxt.out = s_nxt.level ^ ctl.invert;
		s_nxt.oe = (ctl.mode == TSC_MODE_CMP)
			|| (ctl.mode == TSC_MODE_PWM);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pinOut = s_r.out;
	assign pinOe  = s_r.oe;
endmodule

/* File: tsc_timer.sv */
// Timer top: AXI4-Lite register file, counter core and pin driver
//
// Functional notes
// - Count readable: bits 7..0 in one register, bits 9..8 in another.
// - Upper six bits of both high registers read zero.
// - Compare-A is 10-bit read/write, low and high parts, reset zero.
// - Mode 00 compare output, 11 timer/counter, 10 PWM.
// - Compare mode, clear-select low: clear on period match; both flags.
// - Clear-select high: clear on compare-A match; no period flag.
// - Compare mode: only compare-A matches move the pin.
// - Compare-A match drives pin high, low, toggles, or leaves it.
// - Counter-on rising edge loads the pin with its initial level.
// - Timer/counter mode counts like compare mode, pin not driven.
// - PWM ignores clear-select; one comparator sets period.
// - Swap zero: period comparator gives period, compare-A duty.
// - Period is code times 128 clocks; code zero gives 1024.
// - PWM sets separate flags for compare-A and period matches.
// - PWM: initial level picks polarity; action enables or forces pin.
// - Invert bit inverts the waveform on the pin.
// - Duty at or above period holds the active level.
// - Period code compares with the top three bits of the next count; low seven bits must be zero.
// - Counter-on rise clears count; clearing it keeps count.
// - Pause holds the count; release resumes from it.
`timescale 1ns/10ps
module tsc_timer
	import tsc_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             pinOut,
	output logic             pinOe
);
	typedef struct packed {
		logic       awRdy;
		logic       awGot;
		logic [4:0] awAddr;
		logic       wRdy;
		logic       wGot;
		logic [7:0] wByte;
		logic       wEn;
		logic       bvalid;
		logic [1:0] bresp;
		logic       arRdy;
		logic       rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [9:0] cmpA;
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic       flagA;
		logic       flagP;
	} tsc_top_t;

	tsc_top_t s_r;
	tsc_top_t s_nxt;

	tsc_ctl_if ctl ();

	function automatic logic isMapped(input logic [4:0] addr);
		isMapped = (addr == TSC_OFF_CNT_LO) || (addr == TSC_OFF_CNT_HI)
			|| (addr == TSC_OFF_CMPA_LO) || (addr == TSC_OFF_CMPA_HI)
			|| (addr == TSC_OFF_CTRL0) || (addr == TSC_OFF_CTRL1)
			|| (addr == TSC_OFF_STAT);
	endfunction

	always_comb begin
		s_nxt = s_r;
		// Address and data are taken independently
		if (s_axi_awvalid && s_r.awRdy) begin
			s_nxt.awGot = 1'b1;
			s_nxt.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wRdy) begin
			s_nxt.wGot = 1'b1;
			s_nxt.wByte = s_axi_wdata[7:0];
			s_nxt.wEn = s_axi_wstrb[0];
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		// Commit once both halves are held
		if (s_r.awGot && s_r.wGot) begin
			s_nxt.awGot = 1'b0;
			s_nxt.wGot = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = isMapped(s_r.awAddr) ? TSC_RESP_OKAY
				: TSC_RESP_SLVERR;
			if (s_r.wEn) begin
				unique case (s_r.awAddr)
					TSC_OFF_CMPA_LO: s_nxt.cmpA[7:0] = s_r.wByte;
					TSC_OFF_CMPA_HI: s_nxt.cmpA[9:8] = s_r.wByte[1:0];
					TSC_OFF_CTRL0: s_nxt.ctrl0 = s_r.wByte;
					TSC_OFF_CTRL1: s_nxt.ctrl1 = s_r.wByte;
					TSC_OFF_STAT: begin
						s_nxt.flagA = s_r.flagA && !s_r.wByte[TSC_FLAGA_BIT];
						s_nxt.flagP = s_r.flagP && !s_r.wByte[TSC_FLAGP_BIT];
					end
					default: s_nxt.cmpA = s_r.cmpA;
				endcase
			end
		end
		// A new match wins over a clear in the same cycle
		if (ctl.hitA) begin
			s_nxt.flagA = 1'b1;
		end
		if (ctl.hitP) begin
			s_nxt.flagP = 1'b1;
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_r.arRdy) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = isMapped(s_axi_araddr) ? TSC_RESP_OKAY
				: TSC_RESP_SLVERR;
			unique case (s_axi_araddr)
				TSC_OFF_CNT_LO:  s_nxt.rdata = ctl.cnt[7:0];
				TSC_OFF_CNT_HI:  s_nxt.rdata = {6'h00, ctl.cnt[9:8]};
				TSC_OFF_CMPA_LO: s_nxt.rdata = s_r.cmpA[7:0];
				TSC_OFF_CMPA_HI: s_nxt.rdata = {6'h00, s_r.cmpA[9:8]};
				TSC_OFF_CTRL0:   s_nxt.rdata = s_r.ctrl0;
				TSC_OFF_CTRL1:   s_nxt.rdata = s_r.ctrl1;
				TSC_OFF_STAT:    s_nxt.rdata = {6'h00, s_r.flagP, s_r.flagA};
				default:         s_nxt.rdata = 8'h00;
			endcase
		end
		s_nxt.awRdy = !s_nxt.awGot && !s_nxt.bvalid;
		s_nxt.wRdy = !s_nxt.wGot && !s_nxt.bvalid;
		s_nxt.arRdy = !s_nxt.rvalid;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.cmpA <= TSC_CMPA_RST;
			s_r.ctrl0 <= TSC_CTRL_RST;
			s_r.ctrl1 <= TSC_CTRL_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Control fields to the counter and pin logic
	assign ctl.mode = tsc_mode_t'(s_r.ctrl1[TSC_MODE_LSB +: 2]);
	assign ctl.action = s_r.ctrl1[TSC_ACT_LSB +: 2];
	assign ctl.initLevel = s_r.ctrl1[TSC_INIT_BIT];
	assign ctl.invert = s_r.ctrl1[TSC_INV_BIT];
	assign ctl.swap = s_r.ctrl1[TSC_SWAP_BIT];
	assign ctl.clrSel = s_r.ctrl1[TSC_CLR_BIT];
	assign ctl.counterOn = s_r.ctrl0[TSC_ON_BIT];
	assign ctl.pause = s_r.ctrl0[TSC_PAUSE_BIT];
	assign ctl.periodCode = s_r.ctrl0[2:0];
	assign ctl.cmpA = s_r.cmpA;

	tsc_count_core u_core (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ctl     (ctl)
	);

	tsc_pin_drive u_pin (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.ctl     (ctl),
		.pinOut  (pinOut),
		.pinOe   (pinOe)
	);

	assign s_axi_awready = s_r.awRdy;
	assign s_axi_wready  = s_r.wRdy;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_arready = s_r.arRdy;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = {24'h000000, s_r.rdata};
	assign s_axi_rresp   = s_r.rresp;

	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	property p_cntLowRead;
		s_axi_arvalid && s_r.arRdy && s_axi_araddr == TSC_OFF_CNT_LO
			|=> s_r.rdata == $past(ctl.cnt[7:0]);
	endproperty
	a_cntLowRead: assert property (p_cntLowRead)
		else $error("count low read mismatch");

	property p_highZero;
		s_axi_arvalid && s_r.arRdy && (s_axi_araddr == TSC_OFF_CNT_HI
			|| s_axi_araddr == TSC_OFF_CMPA_HI)
			|=> s_axi_rvalid && s_axi_rdata[7:2] == 6'h00;
	endproperty
	a_highZero: assert property (p_highZero)
		else $error("high register upper bits not zero");

	property p_cmpWrite;
		s_r.awGot && s_r.wGot && s_r.wEn && s_r.awAddr == TSC_OFF_CMPA_LO
			|=> ctl.cmpA[7:0] == $past(s_r.wByte) && s_axi_bvalid;
	endproperty
	a_cmpWrite: assert property (p_cmpWrite)
		else $error("compare-A low write lost");

	property p_periodClear;
		ctl.hitP && ctl.mode != TSC_MODE_PWM |-> ctl.cnt == 10'h000;
	endproperty
	a_periodClear: assert property (p_periodClear)
		else $error("period match did not clear count");

	property p_noPeriodFlag;
		$past(ctl.clrSel) && $past(ctl.mode) != TSC_MODE_PWM
			|-> !ctl.hitP;
	endproperty
	a_noPeriodFlag: assert property (p_noPeriodFlag)
		else $error("period flag raised with clear-select high");

	property p_pinHigh;
		ctl.mode == TSC_MODE_CMP && ctl.hitA && !ctl.onRise
			&& ctl.action == TSC_ACT_HIGH
			|=> pinOut == !$past(ctl.invert) && pinOe;
	endproperty
	a_pinHigh: assert property (p_pinHigh)
		else $error("pin not driven high on compare-A match");

	property p_initLevel;
		ctl.onRise && ctl.mode == TSC_MODE_CMP
			|=> pinOut == ($past(ctl.initLevel) ^ $past(ctl.invert));
	endproperty
	a_initLevel: assert property (p_initLevel)
		else $error("pin not reset to initial level");

	property p_timerNoPin;
		ctl.mode == TSC_MODE_TMR |=> !pinOe;
	endproperty
	a_timerNoPin: assert property (p_timerNoPin)
		else $error("pin driven in timer/counter mode");

	property p_onClears;
		$rose(ctl.counterOn) |=> ctl.cnt == 10'h000 && ctl.onRise;
	endproperty
	a_onClears: assert property (p_onClears)
		else $error("counter-on rise did not clear count");

	property p_pauseHolds;
		ctl.pause && ctl.counterOn && $past(ctl.counterOn)
			|=> ctl.cnt == $past(ctl.cnt);
	endproperty
	a_pauseHolds: assert property (p_pauseHolds)
		else $error("count moved while paused");

	property p_periodLength;
		ctl.hitP && ctl.mode == TSC_MODE_PWM && !ctl.swap
			&& ctl.periodCode != 3'h0 && $stable(ctl.periodCode)
			|-> $past(ctl.cnt) == 10'(tscCodeTicks(ctl.periodCode)
			- 11'h001);
	endproperty
	a_periodLength: assert property (p_periodLength)
		else $error("PWM period length wrong");

	property p_fullDuty;
		(ctl.mode == TSC_MODE_PWM && !ctl.swap
			&& ctl.action == TSC_ACT_HIGH
			&& {1'b0, ctl.cmpA} >= tscCodeTicks(ctl.periodCode)) [*3]
			|-> pinOut == (ctl.initLevel ^ ctl.invert);
	endproperty
	a_fullDuty: assert property (p_fullDuty)
		else $error("full duty not held active");

	property p_flagSticky;
		ctl.hitA |=> s_r.flagA;
	endproperty
	a_flagSticky: assert property (p_flagSticky)
		else $error("compare-A flag not set");

	property p_cmpHighRead;
		s_axi_arvalid && s_r.arRdy && s_axi_araddr == TSC_OFF_CMPA_HI
			|=> s_r.rdata == {6'h00, $past(s_r.cmpA[9:8])};
	endproperty
	a_cmpHighRead: assert property (p_cmpHighRead)
		else $error("compare-A high read mismatch");

	property p_pinOnlyA;
		ctl.mode == TSC_MODE_CMP && !ctl.hitA && !ctl.onRise
			&& $stable(ctl.invert) |=> $stable(pinOut);
	endproperty
	a_pinOnlyA: assert property (p_pinOnlyA)
		else $error("pin moved without a compare-A match");

	property p_pwmForced;
		ctl.mode == TSC_MODE_PWM && ctl.action == TSC_ACT_OFF
			|=> pinOut == (!$past(ctl.initLevel) ^ $past(ctl.invert));
	endproperty
	a_pwmForced: assert property (p_pwmForced)
		else $error("forced inactive level wrong");

	property p_pinInvert;
		ctl.mode == TSC_MODE_PWM && ctl.action == TSC_ACT_ON
			|=> pinOut == ($past(ctl.initLevel) ^ $past(ctl.invert));
	endproperty
	a_pinInvert: assert property (p_pinInvert)
		else $error("pin polarity not applied");

	property p_pwmDuty;
		!$past(ctl.swap) && $stable(ctl.cmpA) && $stable(ctl.periodCode)
			|-> ctl.pwmAct == (ctl.cnt < ctl.cmpA
			|| {1'b0, ctl.cmpA} >= tscCodeTicks(ctl.periodCode));
	endproperty
	a_pwmDuty: assert property (p_pwmDuty)
		else $error("PWM active window wrong");

	property p_countStep;
		ctl.counterOn && !ctl.pause && $past(ctl.counterOn)
			|=> ctl.cnt == 10'($past(ctl.cnt) + 10'h001)
			|| ctl.cnt == 10'h000;
	endproperty
	a_countStep: assert property (p_countStep)
		else $error("count did not step by one");

	property p_bStands;
		s_axi_bvalid && !s_axi_bready
			|=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bStands: assert property (p_bStands)
		else $error("write response dropped before ready");

	property p_rStands;
		s_axi_rvalid && !s_axi_rready
			|=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rStands: assert property (p_rStands)
		else $error("read data dropped before ready");

	c_cmpToggle: cover property (ctl.mode == TSC_MODE_CMP && ctl.hitA
		&& ctl.action == TSC_ACT_TOG);
	c_pwmPeriod: cover property (ctl.mode == TSC_MODE_PWM && ctl.hitP);
	c_overflow: cover property (ctl.hitP && ctl.periodCode == 3'h0);
	c_slvErr: cover property (s_axi_bvalid
		&& s_axi_bresp == TSC_RESP_SLVERR);
	c_pwmSwap: cover property (ctl.mode == TSC_MODE_PWM && ctl.swap
		&& ctl.hitA);
endmodule

/* File: tb_standard_timer_compare_pwm.sv */
// Self-checking testbench for the timer over its AXI4-Lite registers
`timescale 1ns/10ps
module tb_standard_timer_compare_pwm;
	import tsc_pkg::*;
	logic        ref_clk;
	logic        rst_n;
	logic [4:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [4:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        pinOut;
	logic        pinOe;
	int          n_errors;
	int          compares;
	int          cycles;

	tsc_timer dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pinOut(pinOut), .pinOe(pinOe));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic results;
		if (n_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard: the whole sequence needs well under this many cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			results();
		end
	end

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	// One write: address and data offered together, each released when taken
	task automatic axiWr(input logic [4:0] a, input logic [7:0] d,
		input logic [1:0] expResp);
		logic awDone;
		logic wDone;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		awDone = 1'b0;
		wDone = 1'b0;
		while (!(awDone && wDone)) begin
			@(posedge ref_clk);
			if (awvalid && awready === 1'b1) begin
				awvalid <= 1'b0;
				awDone = 1'b1;
			end
			if (wvalid && wready === 1'b1) begin
				wvalid <= 1'b0;
				wDone = 1'b1;
			end
		end
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		check("bresp", {30'h0, bresp}, {30'h0, expResp});
	endtask

	task automatic axiRd(input logic [4:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		axiWr(a, d, TSC_RESP_OKAY);
	endtask

	task automatic rdChk(input string name, input logic [4:0] a,
		input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axiRd(a, d, r);
		check(name, d, exp);
		check("rresp", {30'h0, r}, {30'h0, TSC_RESP_OKAY});
	endtask

	task automatic cfg(input logic [7:0] c1, input logic [7:0] c0);
		wr(TSC_OFF_CTRL0, 8'h00);
		wr(TSC_OFF_CTRL1, c1);
		wr(TSC_OFF_CTRL0, c0);
	endtask

	task automatic measPin(output int hi, output int lo);
		do @(posedge ref_clk); while (pinOut !== 1'b0);
		do @(posedge ref_clk); while (pinOut !== 1'b1);
		hi = 0;
		lo = 0;
		do begin hi++; @(posedge ref_clk); end while (pinOut === 1'b1);
		do begin lo++; @(posedge ref_clk); end while (pinOut === 1'b0);
	endtask

	task automatic pinTimes(input string name, input int expHi,
		input int expLo);
		int hi;
		int lo;
		measPin(hi, lo);
		check({name, " high"}, 32'(hi), 32'(expHi));
		check({name, " low"}, 32'(lo), 32'(expLo));
	endtask

	// Pin must hold one level for 256 cycles
	task automatic pinSteady(input logic lvl);
		int bad;
		bad = 0;
		repeat (4) @(posedge ref_clk);
		repeat (256) begin
			@(posedge ref_clk);
			if (pinOut !== lvl)
				bad++;
		end
		check("pin steady", 32'(bad), 32'h0);
	endtask

	task automatic testRegs;
		logic [31:0] d;
		logic [1:0]  r;
		rdChk("count lo", TSC_OFF_CNT_LO, 32'h0);
		rdChk("count hi", TSC_OFF_CNT_HI, 32'h0);
		rdChk("cmpa lo rst", TSC_OFF_CMPA_LO, 32'h0);
		rdChk("cmpa hi rst", TSC_OFF_CMPA_HI, 32'h0);
		wr(TSC_OFF_CMPA_LO, 8'ha5);
		wr(TSC_OFF_CMPA_HI, 8'hff);
		rdChk("cmpa lo", TSC_OFF_CMPA_LO, 32'h000000a5);
		rdChk("cmpa hi", TSC_OFF_CMPA_HI, 32'h00000003);
		wr(TSC_OFF_CNT_LO, 8'h55);
		rdChk("count ro", TSC_OFF_CNT_LO, 32'h0);
		axiWr(5'h1c, 8'hff, TSC_RESP_SLVERR);
		axiRd(5'h1c, d, r);
		check("unmapped data", d, 32'h0);
		check("unmapped resp", {30'h0, r}, {30'h0, TSC_RESP_SLVERR});
	endtask

	task automatic testCount;
		logic [31:0] a;
		logic [31:0] b;
		logic [1:0]  r;
		cfg(8'hc0, 8'h08);
		repeat (300) @(posedge ref_clk);
		wr(TSC_OFF_CTRL0, 8'h88);
		axiRd(TSC_OFF_CNT_LO, a, r);
		rdChk("count hi", TSC_OFF_CNT_HI, 32'h1);
		repeat (20) @(posedge ref_clk);
		rdChk("paused", TSC_OFF_CNT_LO, a);
		wr(TSC_OFF_CTRL0, 8'h08);
		axiRd(TSC_OFF_CNT_LO, b, r);
		check("resumed", {31'h0, b > a}, 32'h1);
		wr(TSC_OFF_CTRL0, 8'h00);
		axiRd(TSC_OFF_CNT_LO, a, r);
		repeat (20) @(posedge ref_clk);
		rdChk("residual", TSC_OFF_CNT_LO, a);
		wr(TSC_OFF_CTRL0, 8'h08);
		rdChk("restart hi", TSC_OFF_CNT_HI, 32'h0);
		axiRd(TSC_OFF_CNT_LO, b, r);
		check("restart lo", {31'h0, b < 32'd40}, 32'h1);
		wr(TSC_OFF_STAT, 8'h03);
		repeat (1100) @(posedge ref_clk);
		rdChk("timer flags", TSC_OFF_STAT, 32'h3);
		check("timer pin off", {31'h0, pinOe}, 32'h0);
	endtask

	task automatic testCompare;
		logic [7:0] act[3] = '{8'h00, 8'h10, 8'h20};
		logic       ini[3] = '{1'b1, 1'b1, 1'b0};
		logic       fin[3] = '{1'b1, 1'b0, 1'b1};
		// Compare-A stays nonzero throughout compare mode
		wr(TSC_OFF_CMPA_HI, 8'h00);
		wr(TSC_OFF_CMPA_LO, 8'h14);
		for (int i = 0; i < 3; i++) begin
			cfg(act[i] | {4'h0, ini[i], 3'h0}, 8'h09);
			repeat (4) @(posedge ref_clk);
			check("pin init", {31'h0, pinOut}, {31'h0, ini[i]});
			repeat (60) @(posedge ref_clk);
			check("pin action", {31'h0, pinOut}, {31'h0, fin[i]});
		end
		check("cmp pin on", {31'h0, pinOe}, 32'h1);
		wr(TSC_OFF_CMPA_LO, 8'h32);
		cfg(8'h38, 8'h09);
		wr(TSC_OFF_STAT, 8'h03);
		pinTimes("toggle", 128, 128);
		rdChk("flags clr0", TSC_OFF_STAT, 32'h3);
		wr(TSC_OFF_CMPA_LO, 8'hc8);
		cfg(8'h39, 8'h09);
		wr(TSC_OFF_STAT, 8'h03);
		pinTimes("clear on a", 201, 201);
		rdChk("flags clr1", TSC_OFF_STAT, 32'h1);
	endtask

	task automatic testPwm;
		wr(TSC_OFF_CMPA_LO, 8'h20);
		cfg(8'ha9, 8'h09);
		wr(TSC_OFF_STAT, 8'h03);
		pinTimes("pwm", 32, 96);
		rdChk("pwm flags", TSC_OFF_STAT, 32'h3);
		check("pwm pin on", {31'h0, pinOe}, 32'h1);
		cfg(8'had, 8'h09);
		pinTimes("pwm inv", 96, 32);
		cfg(8'ha1, 8'h09);
		pinTimes("pwm act low", 96, 32);
		cfg(8'h99, 8'h09);
		pinSteady(1'b1);
		cfg(8'h89, 8'h09);
		pinSteady(1'b0);
		wr(TSC_OFF_CMPA_LO, 8'hc8);
		cfg(8'ha9, 8'h09);
		pinSteady(1'b1);
		// Swapped roles: compare-A sets 384 clocks, period code 128 duty
		wr(TSC_OFF_CMPA_HI, 8'h01);
		wr(TSC_OFF_CMPA_LO, 8'h7f);
		cfg(8'hab, 8'h09);
		pinTimes("pwm swap", 128, 256);
	endtask

	initial begin
		n_errors = 0;
		compares = 0;
		cycles = 0;
		rst_n = 1'b0;
		awaddr = 5'h00;
		awvalid = 1'b0;
		wdata = 32'h00000000;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 5'h00;
		arvalid = 1'b0;
		rready = 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		testRegs();
		testCount();
		testCompare();
		testPwm();
		results();
	end
endmodule
